// *** rtl/scd_pkg.sv ***
/*
 * Shared constants and types for the compensation distributor: bus widths,
 * register offsets, field positions, reset values, destination indices and
 * the selector carrier struct.
 * Assumes a single 200 MHz system clock domain for every user of it.
 */
package scd_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    localparam int FACTOR_W = 32;
    localparam int NUM_DEST = 6;
    localparam int NUM_COMP = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_ROUTE_AUX = 16'h0280;
    localparam logic [ADDR_W-1:0] OFS_ROUTE_NCO = 16'h0281;
    localparam logic [ADDR_W-1:0] OFS_ROUTE_DPLL = 16'h0282;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int FLD_LO_LSB = 0;
    localparam int FLD_HI_LSB = 4;
    localparam logic [SEL_W-1:0] RST_SEL = 3'h0;
    localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;

    // ------------------------------------------------------------------
    // Selector codes: code zero means no compensation
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] COMP_NONE = 3'h0;

    // ------------------------------------------------------------------
    // Destination indices
    // ------------------------------------------------------------------
    localparam int DEST_AUX_DPLL = 0;
    localparam int DEST_TDC = 1;
    localparam int DEST_NCO0 = 2;
    localparam int DEST_NCO1 = 3;
    localparam int DEST_DPLL0 = 4;
    localparam int DEST_DPLL1 = 5;

    typedef struct packed {
        logic [SEL_W-1:0] aux_dpll;
        logic [SEL_W-1:0] tdc;
        logic [SEL_W-1:0] nco0;
        logic [SEL_W-1:0] nco1;
        logic [SEL_W-1:0] dpll0;
        logic [SEL_W-1:0] dpll1;
    } scd_route_t;

endpackage

// *** rtl/scd_distributor.sv ***
/*
 * Compensation distributor: three software registers holding six 3-bit
 * selectors, each routing one of composite factors 1 to 7, or zero for code 0, to a destination.
 * Assumes the combiner supplies all eight composite factors on the system
 * clock, and a bus master with one-cycle strobes that never overlap.
 */
// Notes on behaviour
// - Three 8-bit registers hold six selectors
// - One selector field per destination
// - Selector value picks delivered composite factor
// - Any destination takes any factor 1 to 7 independently
// - NCO 0 selector in low bits 0x0281
// - Code zero gives zero; bits pick methods
`timescale 1ns/1ps

module scd_distributor (
    input wire logic i_clk_sys,
    input wire logic i_reset,
    input wire logic [scd_pkg::ADDR_W-1:0] i_addr,
    input wire logic [scd_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [scd_pkg::DATA_W-1:0] o_rdata,
    input wire logic [scd_pkg::NUM_COMP-1:0][scd_pkg::FACTOR_W-1:0] i_composite_factor,
    output logic [scd_pkg::NUM_DEST-1:0][scd_pkg::FACTOR_W-1:0] o_dest_factor,
    output scd_pkg::scd_route_t o_route
);

    // ------------------------------------------------------------------
    // Selector registers
    // ------------------------------------------------------------------
    scd_pkg::scd_route_t route_q;
    logic [scd_pkg::DATA_W-1:0] rdata_q;
    logic [scd_pkg::DATA_W-1:0] rdata_d;
    logic [scd_pkg::NUM_DEST-1:0][scd_pkg::SEL_W-1:0] sel_w;
    logic [scd_pkg::NUM_DEST-1:0][scd_pkg::FACTOR_W-1:0] factor_q;
    logic [scd_pkg::SEL_W-1:0] wr_lo_w;
    logic [scd_pkg::SEL_W-1:0] wr_hi_w;
    logic [scd_pkg::SEL_W-1:0] rd_lo_w;
    logic [scd_pkg::SEL_W-1:0] rd_hi_w;
    logic miss_w;

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            route_q.aux_dpll <= scd_pkg::RST_SEL;
            route_q.tdc <= scd_pkg::RST_SEL;
            route_q.nco0 <= scd_pkg::RST_SEL;
            route_q.nco1 <= scd_pkg::RST_SEL;
            route_q.dpll0 <= scd_pkg::RST_SEL;
            route_q.dpll1 <= scd_pkg::RST_SEL;
        end else if (i_wr) begin
            // Each offset touches only its own two fields
            case (i_addr)
                scd_pkg::OFS_ROUTE_AUX: begin
                    route_q.aux_dpll <= i_wdata[scd_pkg::FLD_LO_LSB +: scd_pkg::SEL_W];
                    route_q.tdc <= i_wdata[scd_pkg::FLD_HI_LSB +: scd_pkg::SEL_W];
                end
                scd_pkg::OFS_ROUTE_NCO: begin
                    route_q.nco0 <= i_wdata[scd_pkg::FLD_LO_LSB +: scd_pkg::SEL_W];
                    route_q.nco1 <= i_wdata[scd_pkg::FLD_HI_LSB +: scd_pkg::SEL_W];
                end
                scd_pkg::OFS_ROUTE_DPLL: begin
                    route_q.dpll0 <= i_wdata[scd_pkg::FLD_LO_LSB +: scd_pkg::SEL_W];
                    route_q.dpll1 <= i_wdata[scd_pkg::FLD_HI_LSB +: scd_pkg::SEL_W];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read path, data valid the cycle after the strobe only
    // ------------------------------------------------------------------
    always_comb begin
        rdata_d = scd_pkg::RST_RDATA;
        case (i_addr)
            scd_pkg::OFS_ROUTE_AUX: begin
                rdata_d[scd_pkg::FLD_LO_LSB +: scd_pkg::SEL_W] = route_q.aux_dpll;
                rdata_d[scd_pkg::FLD_HI_LSB +: scd_pkg::SEL_W] = route_q.tdc;
            end
            scd_pkg::OFS_ROUTE_NCO: begin
                rdata_d[scd_pkg::FLD_LO_LSB +: scd_pkg::SEL_W] = route_q.nco0;
                rdata_d[scd_pkg::FLD_HI_LSB +: scd_pkg::SEL_W] = route_q.nco1;
            end
            scd_pkg::OFS_ROUTE_DPLL: begin
                rdata_d[scd_pkg::FLD_LO_LSB +: scd_pkg::SEL_W] = route_q.dpll0;
                rdata_d[scd_pkg::FLD_HI_LSB +: scd_pkg::SEL_W] = route_q.dpll1;
            end
            default: begin
                rdata_d = scd_pkg::RST_RDATA;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            rdata_q <= scd_pkg::RST_RDATA;
        end else if (i_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= scd_pkg::RST_RDATA;
        end
    end

    // ------------------------------------------------------------------
    // Routing matrix
    // ------------------------------------------------------------------
    assign sel_w[scd_pkg::DEST_AUX_DPLL] = route_q.aux_dpll;
    assign sel_w[scd_pkg::DEST_TDC] = route_q.tdc;
    assign sel_w[scd_pkg::DEST_NCO0] = route_q.nco0;
    assign sel_w[scd_pkg::DEST_NCO1] = route_q.nco1;
    assign sel_w[scd_pkg::DEST_DPLL0] = route_q.dpll0;
    assign sel_w[scd_pkg::DEST_DPLL1] = route_q.dpll1;

    // Aux DPLL is not guarded against method three; software avoids that loop
    always_ff @(posedge i_clk_sys) begin
        for (int d = 0; d < scd_pkg::NUM_DEST; d++) begin
            if (i_reset) begin
                factor_q[d] <= '0;
            end else if (sel_w[d] == scd_pkg::COMP_NONE) begin
                factor_q[d] <= '0;
            end else begin
                factor_q[d] <= i_composite_factor[sel_w[d]];
            end
        end
    end

    generate
        for (genvar g = 0; g < scd_pkg::NUM_DEST; g++) begin : g_dest
            chk_zero_code: assert property (
                @(posedge i_clk_sys) disable iff (i_reset)
                (sel_w[g] == scd_pkg::COMP_NONE) |=> (factor_q[g] == '0)
            ) else $error("Code zero did not give a zero factor");

            chk_route_factor: assert property (
                @(posedge i_clk_sys) disable iff (i_reset)
                (sel_w[g] != scd_pkg::COMP_NONE)
                    |=> (factor_q[g] == $past(i_composite_factor[sel_w[g]]))
            ) else $error("Destination factor does not follow its selector");

            chk_factor_steady: assert property (
                @(posedge i_clk_sys) disable iff (i_reset)
                $stable(sel_w[g]) && $stable(i_composite_factor) |=> $stable(factor_q[g])
            ) else $error("Destination factor moved while its inputs held");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_rdata = rdata_q;
    assign o_dest_factor = factor_q;
    assign o_route = route_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    assign wr_lo_w = i_wdata[scd_pkg::FLD_LO_LSB +: scd_pkg::SEL_W];
    assign wr_hi_w = i_wdata[scd_pkg::FLD_HI_LSB +: scd_pkg::SEL_W];
    assign rd_lo_w = o_rdata[scd_pkg::FLD_LO_LSB +: scd_pkg::SEL_W];
    assign rd_hi_w = o_rdata[scd_pkg::FLD_HI_LSB +: scd_pkg::SEL_W];
    assign miss_w = (i_addr != scd_pkg::OFS_ROUTE_AUX) && (i_addr != scd_pkg::OFS_ROUTE_NCO)
        && (i_addr != scd_pkg::OFS_ROUTE_DPLL);

    sequence s_write_nco;
        i_wr && (i_addr == scd_pkg::OFS_ROUTE_NCO);
    endsequence

    sequence s_read_nco;
        i_rd && (i_addr == scd_pkg::OFS_ROUTE_NCO);
    endsequence

    property p_write_then_read;
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_nco ##1 s_read_nco |=> (rd_lo_w == $past(wr_lo_w, 2))
            && (rd_hi_w == $past(wr_hi_w, 2));
    endproperty

    chk_nco_readback: assert property (p_write_then_read)
        else $error("NCO 0 selector not read back from low bits");

    chk_nco_write: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_nco |=> (route_q.nco0 == $past(wr_lo_w))
            && (route_q.nco1 == $past(wr_hi_w))
    ) else $error("NCO register write not stored");

    chk_fields_apart: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_nco |=> $stable(route_q.aux_dpll) && $stable(route_q.tdc)
            && $stable(route_q.dpll0) && $stable(route_q.dpll1)
    ) else $error("NCO register write disturbed another destination");

    chk_route_hold: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        !i_wr |=> $stable(route_q)
    ) else $error("Selectors changed without a write");

    chk_rsvd_zero: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        i_rd |=> (o_rdata[7] == 1'b0) && (o_rdata[3] == 1'b0)
    ) else $error("Reserved read bits not zero");

    chk_idle_rdata: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        !i_rd |=> (o_rdata == scd_pkg::RST_RDATA)
    ) else $error("Read data present without a read strobe");

    chk_reset_clear: assert property (
        @(posedge i_clk_sys)
        i_reset |=> (route_q == '0) && (o_rdata == scd_pkg::RST_RDATA)
            && (factor_q == '0)
    ) else $error("Reset did not clear selectors and outputs");

    chk_any_factor: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        (route_q.dpll1 == 3'h7) |=> (factor_q[scd_pkg::DEST_DPLL1]
            == $past(i_composite_factor[7]))
    ) else $error("Highest composite factor not reachable");

    // ------------------------------------------------------------------
    // Write and read checks for the other two registers
    // ------------------------------------------------------------------
    sequence s_write_aux;
        i_wr && (i_addr == scd_pkg::OFS_ROUTE_AUX);
    endsequence

    sequence s_read_aux;
        i_rd && (i_addr == scd_pkg::OFS_ROUTE_AUX);
    endsequence

    sequence s_write_dpll;
        i_wr && (i_addr == scd_pkg::OFS_ROUTE_DPLL);
    endsequence

    sequence s_read_dpll;
        i_rd && (i_addr == scd_pkg::OFS_ROUTE_DPLL);
    endsequence

    chk_aux_write: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_aux |=> (route_q.aux_dpll == $past(wr_lo_w))
            && (route_q.tdc == $past(wr_hi_w))
    ) else $error("Aux DPLL register write not stored");

    chk_aux_apart: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_aux |=> $stable(route_q.nco0) && $stable(route_q.nco1)
            && $stable(route_q.dpll0) && $stable(route_q.dpll1)
    ) else $error("Aux DPLL register write disturbed another destination");

    chk_aux_read: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_aux ##1 s_read_aux |=> (rd_lo_w == $past(wr_lo_w, 2))
            && (rd_hi_w == $past(wr_hi_w, 2))
    ) else $error("Aux DPLL register not read back");

    chk_dpll_write: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_dpll |=> (route_q.dpll0 == $past(wr_lo_w))
            && (route_q.dpll1 == $past(wr_hi_w))
    ) else $error("DPLL register write not stored");

    chk_dpll_apart: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_dpll |=> $stable(route_q.aux_dpll) && $stable(route_q.tdc)
            && $stable(route_q.nco0) && $stable(route_q.nco1)
    ) else $error("DPLL register write disturbed another destination");

    chk_dpll_read: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_dpll ##1 s_read_dpll |=> (rd_lo_w == $past(wr_lo_w, 2))
            && (rd_hi_w == $past(wr_hi_w, 2))
    ) else $error("DPLL register not read back");

    // ------------------------------------------------------------------
    // Unmapped offsets and read data lifetime
    // ------------------------------------------------------------------
    sequence s_write_none;
        i_wr && miss_w;
    endsequence

    sequence s_read_none;
        i_rd && miss_w;
    endsequence

    sequence s_lone_read;
        i_rd ##1 !i_rd;
    endsequence

    chk_unmapped_write: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_write_none |=> $stable(route_q)
    ) else $error("Write to an unmapped offset changed a selector");

    chk_unmapped_read: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_read_none |=> (o_rdata == scd_pkg::RST_RDATA)
    ) else $error("Read of an unmapped offset returned data");

    chk_rdata_pulse: assert property (
        @(posedge i_clk_sys) disable iff (i_reset)
        s_lone_read |=> (o_rdata == scd_pkg::RST_RDATA)
    ) else $error("Read data stood longer than one cycle");

endmodule

// *** dv/test_scd_distributor.sv ***
/*
 * Self-checking bench for the compensation distributor: register access,
 * routing of every code to every destination (aux DPLL gets codes 0 to 3 only), reserved bits, unmapped
 * offset and a reset in mid-run.
 * Assumes the design's assertions live in its own files.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end

module test_scd_distributor;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [scd_pkg::ADDR_W-1:0] addr = '0;
    logic [scd_pkg::DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [scd_pkg::NUM_COMP-1:0][scd_pkg::FACTOR_W-1:0] cf = '0;
    logic [scd_pkg::NUM_DEST-1:0][scd_pkg::FACTOR_W-1:0] dest;
    scd_pkg::scd_route_t route;
    logic [scd_pkg::DATA_W-1:0] rdata;
    logic [7:0] rd_q [$];
    logic pend = 1'b0;
    logic [7:0] exp_rd;
    logic [2:0] code [6];
    int failures = 0;
    int checked = 0;

    scd_distributor scd_distributor_inst (.i_clk_sys(clk), .i_reset(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_composite_factor(cf),
        .o_dest_factor(dest), .o_route(route));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Bus cycles; a read notes its expected data
    // ------------------------------------------------------------------
    // Starts right after an edge; strobes run back to back until release_bus
    task automatic op(input logic w, input logic [15:0] a, input logic [7:0] d,
                      input logic [7:0] e);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        if (!w) begin
            rd_q.push_back(e);
        end
        @(posedge clk);
    endtask

    task automatic release_bus();
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic prog();
        logic [7:0] v;
        @(posedge clk);
        for (int r = 0; r < 3; r++) begin
            v = {1'b0, code[2*r+1], 1'b0, code[2*r]};
            op(1'b1, scd_pkg::OFS_ROUTE_AUX + 16'(r), v | 8'($urandom & 8'h88), 8'h00);
            op(1'b0, scd_pkg::OFS_ROUTE_AUX + 16'(r), 8'h00, v);
        end
        release_bus();
    endtask

    task automatic check_out();
        scd_pkg::scd_route_t e;
        repeat (2) @(posedge clk);
        #1;
        e = {code[0], code[1], code[2], code[3], code[4], code[5]};
        `CHK(route, e)
        for (int d = 0; d < 6; d++) begin
            `CHK(dest[d], (code[d] == 3'h0) ? 32'h0 : cf[code[d]])
        end
    endtask

    task automatic new_factors();
        @(posedge clk);
        for (int k = 0; k < 8; k++) begin
            cf[k] <= $urandom;
        end
    endtask

    // ------------------------------------------------------------------
    // Read data monitor: noted value after a read, zero otherwise
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        pend <= rd && !rst;
        if (pend) begin
            exp_rd = rd_q.pop_front();
            `CHK(rdata, exp_rd)
        end else if (!rst) begin
            `CHK(rdata, 8'h00)
        end
    end

    initial begin
        #(5 * 20000);
        failures++;
        report_and_stop();
    end

    initial begin
        void'($urandom(54696));
        foreach (code[d]) code[d] = 3'h0;
        new_factors();
        repeat (19) @(posedge clk);
        rst <= 1'b0;
        check_out();
        prog();
        code[2] = 3'h5;
        code[3] = 3'h3;
        prog();
        check_out();
        // Every destination meets every code; aux DPLL stays off method three
        for (int i = 0; i < 8; i++) begin
            foreach (code[d]) code[d] = 3'((i + d) % 8);
            code[0] = code[0] & 3'h3;
            new_factors();
            prog();
            check_out();
            new_factors();
            check_out();
        end
        @(posedge clk);
        op(1'b1, 16'h0283, 8'hff, 8'h00);
        op(1'b0, 16'h0283, 8'h00, 8'h00);
        release_bus();
        check_out();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        foreach (code[d]) code[d] = 3'h0;
        check_out();
        prog();
        repeat (3) @(posedge clk);
        `CHK(rd_q.size(), 0)
        report_and_stop();
    end
endmodule
